// *** verilog/sock_ctl_pkg.sv ***
// package: register map, socket states, buffer layout for the socket block
`default_nettype none
package sock_ctl_pkg;
    localparam int          NUM_SOCKETS   = 8;
    localparam logic [15:0] TX_BUF_BASE   = 16'h8000;
    localparam logic [15:0] RX_BUF_BASE   = 16'hc000;
    localparam logic [15:0] BUF_MASK      = 16'h07ff;
    // register indices, address = {socket[2:0], index[3:0]}, socket regs
    localparam logic [3:0]  REG_MODE      = 4'h0;
    localparam logic [3:0]  REG_CMD       = 4'h1;
    localparam logic [3:0]  REG_STATE     = 4'h2;
    localparam logic [3:0]  REG_PORT      = 4'h3;
    localparam logic [3:0]  REG_EVT       = 4'h4;
    localparam logic [3:0]  REG_EVT_MASK  = 4'h5;
    localparam logic [3:0]  REG_TX_BASE   = 4'h6;
    localparam logic [3:0]  REG_RX_BASE   = 4'h7;
    localparam logic [3:0]  REG_BUF_MASK  = 4'h8;
    // chip-level registers when address bit 7 is set
    localparam logic [3:0]  REG_SUMMARY   = 4'h0;
    localparam logic [3:0]  REG_CHIP_MASK = 4'h1;
    localparam logic [3:0]  REG_CLEAR     = 4'h2;
    localparam logic [3:0]  REG_ENABLE    = 4'h3;
    localparam logic [7:0]  EVT_MASK_RST  = 8'hff;
    localparam logic [7:0]  CHIP_MASK_RST = 8'h00;
    // protocol modes
    localparam logic [3:0]  MODE_CLOSED   = 4'h0;
    localparam logic [3:0]  MODE_TCP      = 4'h1;
    localparam logic [3:0]  MODE_UDP      = 4'h2;
    localparam logic [3:0]  MODE_RAW_IP   = 4'h3;
    localparam logic [3:0]  MODE_RAW_FRM  = 4'h4;
    // commands
    localparam logic [7:0]  CMD_OPEN      = 8'h01;
    localparam logic [7:0]  CMD_LISTEN    = 8'h02;
    localparam logic [7:0]  CMD_CLOSE     = 8'h10;
    localparam int          CON_BIT       = 0;
    localparam int          SYNACK_CYCLES = 2;

    typedef enum logic [7:0] {
        ST_CLOSED     = 8'h00,
        ST_INIT       = 8'h13,
        ST_LISTEN     = 8'h14,
        ST_SYN_RECV   = 8'h16,
        ST_CONNECTED  = 8'h17,
        ST_UDP        = 8'h22,
        ST_RAW_IP     = 8'h32,
        ST_RAW_FRM    = 8'h42
    } sock_state_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_s;
endpackage : sock_ctl_pkg
`default_nettype wire

// *** verilog/sock_unit.sv ***
// one socket: mode, command, state machine, connected event flag
`timescale 1ns/1ps
`default_nettype none
module sock_unit
    import sock_ctl_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_mode_wr,
    input  wire logic        i_cmd_wr,
    input  wire logic        i_port_wr,
    input  wire logic        i_evt_clr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_syn_seen,
    output logic      [3:0]  o_mode,
    output logic      [15:0] o_port,
    output sock_state_e      o_state,
    output logic      [7:0]  o_evt,
    output logic             o_synack
);
    sock_state_e state_q, state_d;
    logic [3:0]  mode_q;
    logic [15:0] port_q;
    logic [7:0]  evt_q;
    logic [1:0]  syn_cnt_q;
    logic        connect_now;
    wire  [7:0]  cmd = i_wdata[7:0];

    assign connect_now = (state_q == ST_SYN_RECV) &&
                         (syn_cnt_q == 2'(SYNACK_CYCLES - 1));

    always_comb begin
        state_d = state_q;
        if (i_cmd_wr && cmd == CMD_CLOSE) begin
            state_d = ST_CLOSED;
        end else if (i_cmd_wr && cmd == CMD_OPEN && state_q == ST_CLOSED) begin
            case (mode_q) // [R02] [R09]
                MODE_TCP:     state_d = ST_INIT;
                MODE_UDP:     state_d = ST_UDP;
                MODE_RAW_IP:  state_d = ST_RAW_IP;
                MODE_RAW_FRM: state_d = ST_RAW_FRM;
                default:      state_d = ST_CLOSED;
            endcase
        end else if (i_cmd_wr && cmd == CMD_LISTEN && state_q == ST_INIT) begin
            state_d = ST_LISTEN; // [R10]
        end else if (state_q == ST_LISTEN && i_syn_seen) begin
            state_d = ST_SYN_RECV; // [R11]
        end else if (connect_now) begin
            state_d = ST_CONNECTED; // [R13]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q   <= ST_CLOSED;
            mode_q    <= MODE_CLOSED;
            port_q    <= 16'h0000;
            evt_q     <= 8'h00;
            syn_cnt_q <= 2'h0;
        end else begin
            state_q <= state_d;
            if (i_mode_wr) mode_q <= i_wdata[3:0];
            if (i_port_wr) port_q <= i_wdata;
            syn_cnt_q <= (state_q == ST_SYN_RECV) ? syn_cnt_q + 2'h1 : 2'h0;
            // set wins over write-one clear
            evt_q <= (evt_q & ~(i_evt_clr ? i_wdata[7:0] : 8'h00)) |
                     (8'(connect_now) << CON_BIT); // [R12]
        end
    end

    assign o_mode   = mode_q;
    assign o_port   = port_q;
    assign o_state  = state_q;
    assign o_evt    = evt_q;
    assign o_synack = (state_q == ST_SYN_RECV) && (syn_cnt_q == 2'h0); // [R11]

    chk_open_init: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_wr && cmd == CMD_OPEN && state_q == ST_CLOSED
         && mode_q == MODE_TCP) |=> state_q == ST_INIT) // [R09]
        else $error("open did not reach initialized");
    chk_listen_go: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_wr && cmd == CMD_LISTEN && state_q == ST_INIT)
        |=> state_q == ST_LISTEN) // [R10]
        else $error("listen not entered");
    sequence s_syn_arrive;
        state_q == ST_LISTEN && i_syn_seen && !i_cmd_wr;
    endsequence
    sequence s_syn_answer;
        o_synack ##1 (state_q == ST_SYN_RECV)
        ##1 (state_q == ST_CONNECTED || $past(i_cmd_wr));
    endsequence
    chk_syn_path: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_syn_arrive |=> s_syn_answer) // [R11]
        else $error("sync-received path broken");
    chk_con_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(state_q == ST_CONNECTED) |-> evt_q[CON_BIT]) // [R12]
        else $error("connected flag missing");
endmodule : sock_unit
`default_nettype wire

// *** verilog/sock_ctl.sv ***
// socket control top: eight sockets, buffer map, event summary and irq
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// R01 - eight independent sockets, all usable at once
// R02 - sockets open as tcp, udp, raw ip or raw frame
// R03 - socket 0 transmit region starts at 0x8000
// R04 - socket 0 receive region starts at 0xc000
// R05 - each region 2 KB, offset mask 0x07ff
// R06 - next socket base is previous base plus mask plus one
// R07 - host programs mac, gateway, netmask, ip before use; this block has no such registers and the testbench writes none
// R08 - host writes mode 0x01 and port, then open
// R09 - open on tcp socket moves state to initialized
// R10 - listen moves initialized socket to listening; host closes on mismatch
// R11 - syn while listening: sync-received, send syn-ack, then connect
// R12 - connection sets connected flag; host clears by writing one
// R13 - connected state shown in state register
// R14 - host forms address as pointer and mask plus base
// R15 - event and mask set summary; chip mask drives low event line
// R16 - host waits for state outcome before next command
module sock_ctl
    import sock_ctl_pkg::*;
#(
    parameter int SOCKETS = NUM_SOCKETS
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_syn_seen,
    output logic      [15:0] o_rdata,
    output logic      [7:0]  o_synack,
    output logic             o_host_event_line_n,
    output logic             o_irq
);
    if (SOCKETS != 8) begin : g_bad_count
        $error("sock_ctl serves exactly eight sockets");
    end

    default clocking cb_chk @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire       chip_sel = i_addr[7];
    wire [2:0] sock_idx = i_addr[6:4];
    wire [3:0] reg_idx  = i_addr[3:0];

    function automatic logic [15:0] tx_base(input logic [2:0] k);
        tx_base = TX_BUF_BASE + {2'b00, k, 11'h000}; // [R03] [R05] [R06]
    endfunction : tx_base

    function automatic logic [15:0] rx_base(input logic [2:0] k);
        rx_base = RX_BUF_BASE + {2'b00, k, 11'h000}; // [R04] [R05] [R06]
    endfunction : rx_base

    // ------------------------------------------------------------
    // sockets
    // ------------------------------------------------------------
    logic [3:0]  s_mode  [8];
    logic [15:0] s_port  [8];
    sock_state_e s_state [8];
    logic [7:0]  s_evt   [8];
    logic [7:0]  evt_mask_q [8];
    logic [7:0]  summary;
    logic [7:0]  chip_mask_q;
    logic [7:0]  irq_en_q;
    logic [7:0]  irq_stat_q;
    logic [7:0]  prev_state_conn_q;
    logic [15:0] rdata_q;

    for (genvar g = 0; g < 8; g++) begin : g_sock // [R01]
        wire hit = i_wr && !chip_sel && (sock_idx == 3'(g));
        sock_unit u_sock (
            .i_sys_clk (i_sys_clk),
            .i_rst     (i_rst),
            .i_mode_wr (hit && reg_idx == REG_MODE),
            .i_cmd_wr  (hit && reg_idx == REG_CMD),
            .i_port_wr (hit && reg_idx == REG_PORT),
            .i_evt_clr (hit && reg_idx == REG_EVT), // [R12]
            .i_wdata   (i_wdata),
            .i_syn_seen(i_syn_seen[g]),
            .o_mode    (s_mode[g]),
            .o_port    (s_port[g]),
            .o_state   (s_state[g]),
            .o_evt     (s_evt[g]),
            .o_synack  (o_synack[g])
        );
        assign summary[g] = |(s_evt[g] & evt_mask_q[g]); // [R15]

        always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
                evt_mask_q[g] <= EVT_MASK_RST;
            end else if (hit && reg_idx == REG_EVT_MASK) begin
                evt_mask_q[g] <= i_wdata[7:0];
            end
        end
    end

    assign o_host_event_line_n = ~|(summary & chip_mask_q); // [R15]

    // ------------------------------------------------------------
    // chip registers and connection interrupt
    // ------------------------------------------------------------
    wire chip_wr = i_wr && chip_sel;
    logic [7:0] now_conn;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            now_conn[k] = (s_state[k] == ST_CONNECTED);
        end
    end
    wire [7:0] conn_rise = now_conn & ~prev_state_conn_q;
    wire [7:0] irq_clr   = (chip_wr && reg_idx == REG_CLEAR) ?
                           i_wdata[7:0] : 8'h00;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            chip_mask_q       <= CHIP_MASK_RST;
            irq_en_q          <= 8'h00;
            irq_stat_q        <= 8'h00;
            prev_state_conn_q <= 8'h00;
        end else begin
            if (chip_wr && reg_idx == REG_CHIP_MASK) chip_mask_q <= i_wdata[7:0];
            if (chip_wr && reg_idx == REG_ENABLE) irq_en_q <= i_wdata[7:0];
            prev_state_conn_q <= now_conn;
            irq_stat_q <= (irq_stat_q & ~irq_clr) | conn_rise;
        end
    end

    assign o_irq = |(irq_stat_q & irq_en_q);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (chip_sel) begin
            case (reg_idx)
                REG_SUMMARY:   rd_mux = {8'h00, summary};
                REG_CHIP_MASK: rd_mux = {8'h00, chip_mask_q};
                REG_CLEAR:     rd_mux = {8'h00, irq_stat_q};
                REG_ENABLE:    rd_mux = {8'h00, irq_en_q};
                default:       rd_mux = 16'h0000;
            endcase
        end else begin
            case (reg_idx)
                REG_MODE:      rd_mux = {12'h000, s_mode[sock_idx]};
                REG_STATE:     rd_mux = {8'h00, s_state[sock_idx]}; // [R13]
                REG_PORT:      rd_mux = s_port[sock_idx];
                REG_EVT:       rd_mux = {8'h00, s_evt[sock_idx]};
                REG_EVT_MASK:  rd_mux = {8'h00, evt_mask_q[sock_idx]};
                REG_TX_BASE:   rd_mux = tx_base(sock_idx);
                REG_RX_BASE:   rd_mux = rx_base(sock_idx);
                REG_BUF_MASK:  rd_mux = BUF_MASK;
                default:       rd_mux = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= i_rd ? rd_mux : 16'h0000;
        end
    end
    assign o_rdata = rdata_q;

    chk_buf_map: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && !chip_sel && reg_idx == REG_TX_BASE) |=>
        o_rdata == 16'h8000 + {2'b00, $past(sock_idx), 11'h000}) // [R03] [R06]
        else $error("tx base wrong");
    chk_rx_map: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && !chip_sel && reg_idx == REG_RX_BASE) |=>
        o_rdata == 16'hc000 + {2'b00, $past(sock_idx), 11'h000}) // [R04] [R06]
        else $error("rx base wrong");
    chk_mask_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && !chip_sel && reg_idx == REG_BUF_MASK) |=>
        o_rdata == 16'h07ff) // [R05]
        else $error("buffer mask wrong");
    chk_event_line: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (|(summary & chip_mask_q)) |-> !o_host_event_line_n) // [R15]
        else $error("event line not low");

    // ------------------------------------------------------------
    // checks: read path, chip registers, interrupt, event line, syn-ack, reset
    // ------------------------------------------------------------
    sequence s_rd_sock(logic [3:0] r);
        i_rd && !chip_sel && reg_idx == r;
    endsequence

    sequence s_rd_chip(logic [3:0] r);
        i_rd && chip_sel && reg_idx == r;
    endsequence

    chk_rd_idle: assert property ( // [R13]
        !i_rd
        |=> o_rdata == 16'h0000)
        else $error("read data not cleared");

    chk_state_width: assert property ( // [R13]
        s_rd_sock(REG_STATE)
        |=> o_rdata[15:8] == 8'h00)
        else $error("state read too wide");

    chk_mode_width: assert property ( // [R02]
        s_rd_sock(REG_MODE)
        |=> o_rdata[15:4] == 12'h000)
        else $error("mode read too wide");

    chk_evt_width: assert property ( // [R12]
        s_rd_sock(REG_EVT)
        |=> o_rdata[15:8] == 8'h00)
        else $error("event read too wide");

    chk_emask_width: assert property ( // [R15]
        s_rd_sock(REG_EVT_MASK)
        |=> o_rdata[15:8] == 8'h00)
        else $error("event mask read too wide");

    chk_cmd_read: assert property ( // [R16]
        s_rd_sock(REG_CMD)
        |=> o_rdata == 16'h0000)
        else $error("command register readable");

    chk_port_read: assert property ( // [R08]
        s_rd_sock(REG_PORT)
        |=> o_rdata == $past(s_port[sock_idx]))
        else $error("port read wrong");

    chk_sock_unmapped: assert property ( // [R01]
        (i_rd && !chip_sel && reg_idx > REG_BUF_MASK)
        |=> o_rdata == 16'h0000)
        else $error("unmapped socket read not zero");

    chk_chip_unmapped: assert property ( // [R15]
        (i_rd && chip_sel && reg_idx > REG_ENABLE)
        |=> o_rdata == 16'h0000)
        else $error("unmapped chip read not zero");

    chk_tx_region: assert property ( // [R06]
        s_rd_sock(REG_TX_BASE)
        |=> o_rdata[15:14] == 2'b10)
        else $error("tx base outside region");

    chk_rx_region: assert property ( // [R06]
        s_rd_sock(REG_RX_BASE)
        |=> o_rdata[15:14] == 2'b11)
        else $error("rx base outside region");

    chk_tx_align: assert property ( // [R05]
        s_rd_sock(REG_TX_BASE)
        |=> o_rdata[10:0] == 11'h000)
        else $error("tx base not aligned");

    chk_rx_align: assert property ( // [R05]
        s_rd_sock(REG_RX_BASE)
        |=> o_rdata[10:0] == 11'h000)
        else $error("rx base not aligned");

    chk_summary_read: assert property ( // [R15]
        s_rd_chip(REG_SUMMARY)
        |=> o_rdata == {8'h00, $past(summary)})
        else $error("summary read wrong");

    chk_cmask_read: assert property ( // [R15]
        s_rd_chip(REG_CHIP_MASK)
        |=> o_rdata == {8'h00, $past(chip_mask_q)})
        else $error("chip mask read wrong");

    chk_enable_read: assert property ( // [R12]
        s_rd_chip(REG_ENABLE)
        |=> o_rdata == {8'h00, $past(irq_en_q)})
        else $error("enable read wrong");

    chk_status_read: assert property ( // [R12]
        s_rd_chip(REG_CLEAR)
        |=> o_rdata == {8'h00, $past(irq_stat_q)})
        else $error("status read wrong");

    chk_cmask_write: assert property ( // [R15]
        (chip_wr && reg_idx == REG_CHIP_MASK)
        |=> chip_mask_q == $past(i_wdata[7:0]))
        else $error("chip mask not written");

    chk_enable_write: assert property ( // [R12]
        (chip_wr && reg_idx == REG_ENABLE)
        |=> irq_en_q == $past(i_wdata[7:0]))
        else $error("enable not written");

    chk_irq_set: assert property ( // [R12]
        (|conn_rise)
        |=> (irq_stat_q & $past(conn_rise)) == $past(conn_rise))
        else $error("status not set on connect");

    chk_irq_clear: assert property ( // [R12]
        (|irq_clr && !(|conn_rise))
        |=> (irq_stat_q & $past(irq_clr)) == 8'h00)
        else $error("status not cleared");

    chk_irq_sticky: assert property ( // [R12]
        (irq_clr == 8'h00)
        |=> (irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q))
        else $error("status bit lost");

    chk_irq_level: assert property ( // [R12]
        (|(irq_stat_q & irq_en_q))
        |-> o_irq)
        else $error("irq not raised");

    chk_irq_quiet: assert property ( // [R12]
        !(|(irq_stat_q & irq_en_q))
        |-> !o_irq)
        else $error("irq raised without cause");

    chk_line_idle: assert property ( // [R15]
        !(|(summary & chip_mask_q))
        |-> o_host_event_line_n)
        else $error("event line low without cause");

    chk_synack_solo: assert property ( // [R11]
        (|o_synack)
        |=> (o_synack & $past(o_synack)) == 8'h00)
        else $error("syn-ack longer than one cycle");

    chk_reset_regs: assert property ( // [R15]
        $fell(i_rst)
        |-> chip_mask_q == CHIP_MASK_RST && irq_en_q == 8'h00)
        else $error("chip registers not reset");

    chk_reset_outs: assert property ( // [R15]
        $fell(i_rst)
        |-> o_host_event_line_n && !o_irq && o_rdata == 16'h0000)
        else $error("outputs not idle after reset");
endmodule : sock_ctl
`default_nettype wire

// *** verif/remote_peer.sv ***
// far-side peer model: sends connection requests, counts cycles with a syn-ack reply on any socket
`timescale 1ns/1ps
`default_nettype none
module remote_peer (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_send,
    input  wire logic [7:0] i_synack,
    output logic      [7:0] o_syn_seen,
    output logic      [7:0] o_ack_cnt
);
    // ------------------------------------------------------------
    // connection request as a one-cycle pulse per socket
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_syn_seen <= 8'h00;
            o_ack_cnt  <= 8'h00;
        end else begin
            o_syn_seen <= i_send & ~o_syn_seen;
            if (|i_synack) begin
                o_ack_cnt <= o_ack_cnt + 8'h01;
            end
        end
    end
endmodule : remote_peer
`default_nettype wire

// *** verif/tb.sv ***
// testbench for the socket control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sock_ctl_pkg::*;
    logic        i_sys_clk = 1'b0;
    logic        i_rst     = 1'b1;
    logic [7:0]  i_addr    = 8'h00;
    logic [15:0] i_wdata   = 16'h0000;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    logic [7:0]  send      = 8'h00;
    logic [7:0]  syn_seen;
    logic [15:0] o_rdata;
    logic [7:0]  o_synack;
    logic        o_host_event_line_n;
    logic        o_irq;
    logic [7:0]  ack_cnt;
    logic [15:0] rv;
    int          err_total = 0;
    int          cmp_count = 0;

    always #20 i_sys_clk = ~i_sys_clk;

    sock_ctl u_sock_ctl (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_syn_seen(syn_seen), .o_rdata(o_rdata), .o_synack(o_synack),
        .o_host_event_line_n(o_host_event_line_n), .o_irq(o_irq));
    remote_peer u_remote_peer (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_send(send), .i_synack(o_synack), .o_syn_seen(syn_seen),
        .o_ack_cnt(ack_cnt));

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
        #1 rv = o_rdata;
    endtask : rd
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] sa(input int k, input logic [3:0] r);
        return {1'b0, k[2:0], r};
    endfunction : sa
    task automatic test_done;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(sa(2, REG_STATE));    chk(rv, 16'h0000);
        rd(sa(2, REG_EVT_MASK)); chk(rv, 16'h00ff);
        rd(sa(2, REG_CMD));      chk(rv, 16'h0000);
        rd(8'h8f);               chk(rv, 16'h0000);
        chk({15'h0, o_irq}, 16'h0000);
        chk({15'h0, o_host_event_line_n}, 16'h0001);
    endtask : t_reset
    task automatic t_map;
        for (int k = 0; k < 8; k++) begin
            rd(sa(k, REG_TX_BASE));  chk(rv, 16'h8000 + k * 16'h0800);
            chk(rv + (16'h1a2b & 16'h07ff), 16'h822b + k * 16'h0800);
            rd(sa(k, REG_RX_BASE));  chk(rv, 16'hc000 + k * 16'h0800);
            rd(sa(k, REG_BUF_MASK)); chk(rv, 16'h07ff);
        end
    endtask : t_map
    task automatic t_refuse;
        wr(sa(5, REG_CMD), {8'h00, CMD_LISTEN});
        rd(sa(5, REG_STATE)); chk(rv, 16'h0000);
    endtask : t_refuse
    task automatic t_modes;
        logic [3:0] m[4] = '{MODE_TCP, MODE_UDP, MODE_RAW_IP, MODE_RAW_FRM};
        logic [7:0] s[4] = '{8'h13, 8'h22, 8'h32, 8'h42};
        for (int i = 0; i < 4; i++) begin
            wr(sa(4 + i, REG_MODE), {12'h0, m[i]});
            wr(sa(4 + i, REG_CMD), {8'h00, CMD_OPEN});
        end
        for (int i = 0; i < 4; i++) begin
            rd(sa(4 + i, REG_STATE)); chk(rv, {8'h00, s[i]});
        end
        for (int i = 0; i < 4; i++) begin
            wr(sa(4 + i, REG_CMD), {8'h00, CMD_CLOSE});
        end
        rd(sa(5, REG_STATE)); chk(rv, 16'h0000);
    endtask : t_modes
    task automatic t_server;
        int n;
        wr(sa(3, REG_MODE), 16'h0001);
        wr(sa(3, REG_PORT), 16'h1389);
        rd(sa(3, REG_PORT));  chk(rv, 16'h1389);
        wr(sa(3, REG_CMD), {8'h00, CMD_OPEN});
        rd(sa(3, REG_STATE)); chk(rv, 16'h0013);
        wr(sa(3, REG_CMD), {8'h00, CMD_LISTEN});
        rd(sa(3, REG_STATE)); chk(rv, 16'h0014);
        wr(8'h81, 16'h0008);
        wr(8'h83, 16'h0000);
        @(posedge i_sys_clk);
        send <= 8'h08;
        @(posedge i_sys_clk);
        send <= 8'h00;
        n = 0;
        while (o_synack[3] !== 1'b1 && n < 20) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        chk({15'h0, o_synack[3]}, 16'h0001);
        repeat (8) @(posedge i_sys_clk);
        chk({8'h00, ack_cnt}, 16'h0001);
        rd(sa(3, REG_STATE)); chk(rv, 16'h0017);
        rd(sa(3, REG_EVT));   chk(rv, 16'h0001);
        rd(8'h80);            chk(rv, 16'h0008);
        chk({15'h0, o_host_event_line_n}, 16'h0000);
        chk({15'h0, o_irq}, 16'h0000);
        rd(8'h82);            chk(rv, 16'h0008);
        wr(8'h83, 16'h0008);
        #1 chk({15'h0, o_irq}, 16'h0001);
        wr(8'h82, 16'h0008);
        #1 chk({15'h0, o_irq}, 16'h0000);
        wr(sa(3, REG_EVT), 16'h0001);
        rd(sa(3, REG_EVT));   chk(rv, 16'h0000);
        chk({15'h0, o_host_event_line_n}, 16'h0001);
        rd(sa(3, REG_STATE)); chk(rv, 16'h0017);
    endtask : t_server

    initial begin
        #2000000;
        err_total++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_reset();
        t_map();
        t_refuse();
        t_modes();
        t_server();
        test_done();
    end
endmodule : tb
`default_nettype wire
